// >>> design/mao_pkg.sv
package mao_pkg;

    // Memory type of an explicit access, from the address map or protection unit
    typedef enum logic [1:0] {
        MAO_NORMAL,
        MAO_DEV_NS,
        MAO_DEV_SH,
        MAO_STRONG
    } mao_mem_e;

    // Shape of a load or store instruction
    typedef enum logic [2:0] {
        MAO_OP_SINGLE,
        MAO_OP_MULTI_INC,
        MAO_OP_MULTI_DEC,
        MAO_OP_DUAL,
        MAO_OP_SPLIT
    } mao_op_e;

    // The six explicit barriers
    typedef enum logic [2:0] {
        MAO_BAR_SPEC_DATA,
        MAO_BAR_DATA_MEM,
        MAO_BAR_DATA_SYNC,
        MAO_BAR_INSTR_SYNC,
        MAO_BAR_PHYS_BYPASS,
        MAO_BAR_BYPASS
    } mao_bar_e;

    localparam int MAO_ADDR_W    = 32;
    localparam int MAO_WORDS_W   = 5;
    localparam int MAO_OUT_W     = 4;
    localparam int MAO_TOT_W     = 6;
    localparam int MAO_NUM_TYPES = 4;

    localparam logic [MAO_ADDR_W-1:0]  MAO_WORD_BYTES = 32'h0000_0004;
    localparam logic [MAO_WORDS_W-1:0] MAO_ONE_WORD   = 5'h01;
    localparam logic [MAO_WORDS_W-1:0] MAO_TWO_WORDS  = 5'h02;
    localparam logic [MAO_OUT_W-1:0]   MAO_OUT_MAX    = 4'hF;
    localparam logic [MAO_OUT_W-1:0]   MAO_OUT_ZERO   = 4'h0;
    localparam logic [MAO_TOT_W-1:0]   MAO_TOT_ZERO   = 6'h00;

    // Must a1 be globally observed strictly before a2
    function automatic logic mao_must_order(input mao_mem_e a1, input mao_mem_e a2);
        case (a1)
            MAO_DEV_NS: mao_must_order = (a2 == MAO_DEV_NS) || (a2 == MAO_STRONG);
            MAO_DEV_SH: mao_must_order = (a2 == MAO_DEV_SH) || (a2 == MAO_STRONG);
            MAO_STRONG: mao_must_order = (a2 != MAO_NORMAL);
            default:    mao_must_order = 1'b0;
        endcase
    endfunction

endpackage

// >>> design/mao_word_seq.sv
// Splits one instruction into word addresses, always lowest address first
module mao_word_seq
    import mao_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   start,
    input  wire logic                   descend,
    input  wire logic [MAO_ADDR_W-1:0]  base,
    input  wire logic [MAO_WORDS_W-1:0] words,
    input  wire logic                   adv,
    output logic      [MAO_ADDR_W-1:0]  addr,
    output logic                        first,
    output logic                        last
);

    logic [MAO_ADDR_W-1:0]  addr_reg;
    logic [MAO_WORDS_W-1:0] left_reg;
    logic                   first_reg;
    logic [MAO_ADDR_W-1:0]  span;

    assign span = MAO_ADDR_W'(words) << 2;

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg  <= '0;
            left_reg  <= '0;
            first_reg <= 1'b0;
        end else if (start) begin
            // Decrementing form walks its block upward too
            addr_reg  <= descend ? base - span : base;
            left_reg  <= words;
            first_reg <= 1'b1;
        end else if (adv) begin
            addr_reg  <= addr_reg + MAO_WORD_BYTES;
            left_reg  <= left_reg - MAO_ONE_WORD;
            first_reg <= 1'b0;
        end
    end

    assign addr  = addr_reg;
    assign first = first_reg;
    assign last  = (left_reg == MAO_ONE_WORD);

endmodule

// >>> design/mao_order.sv
// Behaviour
// - Device/strong same-class pairs observed strictly in order
// - Normal or mixed-shareability device pairs reorder freely
// - Read feeding later address forces program order
// - Address dependency holds even if value irrelevant
// - Flag-only dependency between reads needs no order
// - Address plus flag dependency uses address ordering
// - Read value used as write data forces order
// - Speculative stores never become visible
// - Never expose a value sequential code would not write
// - Implicit accesses carry no ordering obligation
// - Multi-word instructions split into separately ordered words
// - Accesses of different instructions follow program order
// - Multiple load/store words ascend by address
// - Multiple load including PC may go any order
// - Dual-word halves may go in either order
// - Other atomicity splits may go any order
// - Six barriers drain accesses and flush prefetch
// - Data barriers ignore instruction fetches
// - Speculative-data barrier blocks dependent cache allocation
// - Same protection for dependent indirect branch targets
// - Speculative-data barrier waits until non-speculative
module mao_order
    import mao_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ins_valid,
    output logic                        ins_ready,
    input  wire mao_op_e                ins_op,
    input  wire logic                   ins_write,
    input  wire logic [MAO_ADDR_W-1:0]  ins_base,
    input  wire logic [MAO_WORDS_W-1:0] ins_words,
    input  wire logic                   ins_has_pc,
    input  wire mao_mem_e               ins_mem_type,
    input  wire logic                   ins_addr_dep,
    input  wire logic                   ins_data_dep,
    input  wire logic                   ins_ctrl_dep,
    input  wire logic                   ins_cmov_dep,
    input  wire logic                   ins_spec,
    input  wire logic                   ins_squash,
    input  wire logic                   impl_valid,
    input  wire logic [MAO_ADDR_W-1:0]  impl_addr,
    input  wire logic                   impl_write,
    output logic                        impl_taken,
    output logic                        mem_req_valid,
    input  wire logic                   mem_req_ready,
    output logic      [MAO_ADDR_W-1:0]  mem_addr,
    output logic                        mem_write,
    output mao_mem_e                    mem_type,
    output logic                        mem_implicit,
    output logic                        mem_no_alloc,
    input  wire logic                   mem_done,
    input  wire mao_mem_e               mem_done_type,
    input  wire logic                   mem_done_implicit,
    input  wire logic                   bar_valid,
    input  wire mao_bar_e               bar_kind,
    input  wire logic                   bar_spec,
    output logic                        bar_done,
    output logic                        flush_prefetch,
    input  wire logic                   ibr_valid,
    input  wire logic                   ibr_cmov_dep,
    output logic                        ibr_no_alloc
);

    typedef enum logic [1:0] {
        MAO_ST_IDLE,
        MAO_ST_ISSUE,
        MAO_ST_BAR
    } mao_state_e;

    mao_state_e             st_reg;
    mao_state_e             st_next;
    logic                   ins_ready_reg;
    logic                   impl_taken_reg;
    logic                   mem_req_valid_reg;
    logic [MAO_ADDR_W-1:0]  mem_addr_reg;
    logic                   mem_write_reg;
    mao_mem_e               mem_type_reg;
    logic                   mem_implicit_reg;
    logic                   mem_no_alloc_reg;
    logic                   bar_done_reg;
    logic                   flush_reg;
    logic                   ibr_no_alloc_reg;
    logic                   spec_win_reg;
    mao_bar_e               bar_kind_reg;
    logic [MAO_OUT_W-1:0]   out_cnt_reg [MAO_NUM_TYPES];

    logic                   cur_write_reg;
    mao_mem_e               cur_type_reg;
    logic                   cur_dep_reg;
    logic                   cur_cmov_reg;
    logic                   cur_has_pc_reg;

    logic [MAO_WORDS_W-1:0] words_sel;
    logic [MAO_ADDR_W-1:0]  seq_addr;
    logic                   seq_first;
    logic                   seq_last;
    logic                   take_ins;
    logic                   take_bar;
    logic                   take_sdb;
    logic                   port_free;
    logic                   blocked;
    logic                   issue_now;
    logic                   impl_go;
    logic                   squash_now;
    logic                   bar_drained;
    logic                   sdb_finish;
    logic [MAO_TOT_W-1:0]   total;

    function automatic logic [MAO_TOT_W-1:0] mao_sum(input logic [MAO_OUT_W-1:0] c [MAO_NUM_TYPES]);
        logic [MAO_TOT_W-1:0] s;
        s = MAO_TOT_ZERO;
        for (int i = 0; i < MAO_NUM_TYPES; i++) begin
            s = s + MAO_TOT_W'(c[i]);
        end
        return s;
    endfunction

    // Word counts per instruction shape
    always_comb begin
        case (ins_op)
            MAO_OP_SINGLE: words_sel = MAO_ONE_WORD;
            MAO_OP_DUAL:   words_sel = MAO_TWO_WORDS;
            default:       words_sel = ins_words;
        endcase
    end

    mao_word_seq u_seq (
        .clk     (clk),
        .rst     (rst),
        .start   (take_ins),
        .descend (ins_op == MAO_OP_MULTI_DEC),
        .base    (ins_base),
        .words   (words_sel),
        .adv     (issue_now),
        .addr    (seq_addr),
        .first   (seq_first),
        .last    (seq_last)
    );

    assign total     = mao_sum(out_cnt_reg);
    assign port_free = !mem_req_valid_reg || mem_req_ready;

    // One instruction, or one barrier other than the speculative-data one, at a time keeps instructions in program order
    assign take_ins   = (st_reg == MAO_ST_IDLE) && ins_valid && ins_ready_reg;
    // Barrier still held on its done edge must not be taken a second time
    assign take_sdb   = (st_reg == MAO_ST_IDLE) && !take_ins && bar_valid && !spec_win_reg
                        && (bar_kind == MAO_BAR_SPEC_DATA) && !bar_spec && !bar_done_reg;
    assign take_bar   = (st_reg == MAO_ST_IDLE) && !take_ins && bar_valid && !spec_win_reg
                        && (bar_kind != MAO_BAR_SPEC_DATA) && !bar_done_reg;
    assign squash_now = (st_reg == MAO_ST_ISSUE) && ins_squash && ins_spec;

    // Ordering check for the next word against every explicit access still in flight
    always_comb begin
        blocked = 1'b0;
        for (int i = 0; i < MAO_NUM_TYPES; i++) begin
            // Normal and mixed device pairs pass through here unblocked
            if (out_cnt_reg[i] != MAO_OUT_ZERO && mao_must_order(mao_mem_e'(2'(i)), cur_type_reg)) begin
                blocked = 1'b1;
            end
        end
        // Flag-only dependency is deliberately not looked at
        if (cur_dep_reg && total != MAO_TOT_ZERO) begin
            blocked = 1'b1;
        end
        // Stores wait for commit, so no squashed value ever leaves
        if (cur_write_reg && ins_spec) begin
            blocked = 1'b1;
        end
        if (out_cnt_reg[cur_type_reg] == MAO_OUT_MAX) begin
            blocked = 1'b1;
        end
    end

    assign issue_now = (st_reg == MAO_ST_ISSUE) && !squash_now && !blocked && port_free;
    // Implicit traffic only fills idle port slots and skips every check
    assign impl_go   = impl_valid && !impl_taken_reg && !issue_now && port_free;

    assign bar_drained = (total == MAO_TOT_ZERO) && !mem_req_valid_reg;
    assign sdb_finish  = spec_win_reg && (total == MAO_TOT_ZERO) && !issue_now;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            MAO_ST_IDLE: begin
                if (take_ins) begin
                    st_next = MAO_ST_ISSUE;
                end else if (take_bar) begin
                    st_next = MAO_ST_BAR;
                end
            end
            MAO_ST_ISSUE: begin
                if (squash_now || (issue_now && seq_last)) begin
                    st_next = MAO_ST_IDLE;
                end
            end
            MAO_ST_BAR: begin
                if (bar_drained) begin
                    st_next = MAO_ST_IDLE;
                end
            end
            default: st_next = MAO_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg        <= MAO_ST_IDLE;
            ins_ready_reg <= 1'b0;
        end else begin
            st_reg        <= st_next;
            ins_ready_reg <= (st_next == MAO_ST_IDLE) && !take_ins && !take_bar;
        end
    end

    // Attributes of the instruction being split
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_write_reg  <= 1'b0;
            cur_type_reg   <= MAO_NORMAL;
            cur_dep_reg    <= 1'b0;
            cur_cmov_reg   <= 1'b0;
            cur_has_pc_reg <= 1'b0;
        end else if (take_ins) begin
            cur_write_reg  <= ins_write;
            cur_type_reg   <= ins_mem_type;
            // Taken as given even when the value cannot move the address
            cur_dep_reg    <= ins_addr_dep || ins_data_dep;
            cur_cmov_reg   <= ins_cmov_dep;
            // With PC in the list any order is legal; ascending is kept anyway
            cur_has_pc_reg <= ins_has_pc && !ins_write;
        end
    end

    // Request register toward the memory system
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_req_valid_reg <= 1'b0;
            mem_addr_reg      <= '0;
            mem_write_reg     <= 1'b0;
            mem_type_reg      <= MAO_NORMAL;
            mem_implicit_reg  <= 1'b0;
            mem_no_alloc_reg  <= 1'b0;
        end else if (issue_now) begin
            mem_req_valid_reg <= 1'b1;
            mem_addr_reg      <= seq_addr;
            mem_write_reg     <= cur_write_reg;
            mem_type_reg      <= cur_type_reg;
            mem_implicit_reg  <= 1'b0;
            mem_no_alloc_reg  <= cur_cmov_reg && spec_win_reg;
        end else if (impl_go) begin
            mem_req_valid_reg <= 1'b1;
            mem_addr_reg      <= impl_addr;
            mem_write_reg     <= impl_write;
            mem_type_reg      <= MAO_NORMAL;
            mem_implicit_reg  <= 1'b1;
            mem_no_alloc_reg  <= 1'b0;
        end else if (mem_req_ready) begin
            mem_req_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            impl_taken_reg <= 1'b0;
        end else begin
            impl_taken_reg <= impl_go;
        end
    end

    // In-flight explicit accesses per memory type; counted from issue to done
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < MAO_NUM_TYPES; i++) begin
                out_cnt_reg[i] <= MAO_OUT_ZERO;
            end
        end else begin
            for (int i = 0; i < MAO_NUM_TYPES; i++) begin
                out_cnt_reg[i] <= out_cnt_reg[i]
                    + MAO_OUT_W'(issue_now && cur_type_reg == mao_mem_e'(2'(i)))
                    - MAO_OUT_W'(mem_done && !mem_done_implicit && mem_done_type == mao_mem_e'(2'(i)));
            end
        end
    end

    // Barrier completion: drain explicit accesses, then flush prefetch
    always_ff @(posedge clk) begin
        if (rst) begin
            bar_kind_reg <= MAO_BAR_DATA_MEM;
            bar_done_reg <= 1'b0;
            flush_reg    <= 1'b0;
        end else begin
            if (take_bar || take_sdb) begin
                bar_kind_reg <= bar_kind;
            end
            bar_done_reg <= ((st_reg == MAO_ST_BAR) && bar_drained) || sdb_finish;
            flush_reg    <= ((st_reg == MAO_ST_BAR) && bar_drained) || sdb_finish;
        end
    end

    // Window of the speculative-data barrier; younger instructions keep flowing under it, other barriers wait
    always_ff @(posedge clk) begin
        if (rst) begin
            spec_win_reg <= 1'b0;
        end else if (take_sdb) begin
            spec_win_reg <= 1'b1;
        end else if (sdb_finish) begin
            spec_win_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ibr_no_alloc_reg <= 1'b0;
        end else begin
            ibr_no_alloc_reg <= ibr_valid && ibr_cmov_dep && spec_win_reg;
        end
    end

    assign ins_ready      = ins_ready_reg;
    assign impl_taken     = impl_taken_reg;
    assign mem_req_valid  = mem_req_valid_reg;
    assign mem_addr       = mem_addr_reg;
    assign mem_write      = mem_write_reg;
    assign mem_type       = mem_type_reg;
    assign mem_implicit   = mem_implicit_reg;
    assign mem_no_alloc   = mem_no_alloc_reg;
    assign bar_done       = bar_done_reg;
    assign flush_prefetch = flush_reg;
    assign ibr_no_alloc   = ibr_no_alloc_reg;

    // Checks
    property p_strong_after_device;
        @(posedge clk) disable iff (rst)
        issue_now && cur_type_reg == MAO_STRONG
            |-> out_cnt_reg[MAO_DEV_NS] == MAO_OUT_ZERO && out_cnt_reg[MAO_DEV_SH] == MAO_OUT_ZERO
                && out_cnt_reg[MAO_STRONG] == MAO_OUT_ZERO;
    endproperty
    a_strong_after_device: assert property (p_strong_after_device) else $error("strong access passed device");

    property p_dep_drained;
        @(posedge clk) disable iff (rst)
        issue_now && cur_dep_reg |-> total == MAO_TOT_ZERO;
    endproperty
    a_dep_drained: assert property (p_dep_drained) else $error("dependent access issued early");

    property p_store_committed;
        @(posedge clk) disable iff (rst)
        issue_now && cur_write_reg |=> mem_req_valid_reg && mem_write_reg && !$past(ins_spec);
    endproperty
    a_store_committed: assert property (p_store_committed) else $error("speculative store issued");

    // Implicit traffic may sit between two words, so only explicit addresses are kept
    logic [MAO_ADDR_W-1:0]  last_addr_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            last_addr_reg <= '0;
        end else if (issue_now) begin
            last_addr_reg <= seq_addr;
        end
    end

    property p_ascending;
        @(posedge clk) disable iff (rst)
        issue_now && !seq_first |-> seq_addr == last_addr_reg + MAO_WORD_BYTES;
    endproperty
    a_ascending: assert property (p_ascending) else $error("word order not ascending");

    property p_one_instr;
        @(posedge clk) disable iff (rst)
        ins_ready_reg |-> st_reg == MAO_ST_IDLE;
    endproperty
    a_one_instr: assert property (p_one_instr) else $error("new instruction accepted mid sequence");

    property p_bar_drain;
        @(posedge clk) disable iff (rst)
        $rose(bar_done_reg) |-> $past(total) == MAO_TOT_ZERO && flush_reg;
    endproperty
    a_bar_drain: assert property (p_bar_drain) else $error("barrier done with accesses in flight");

    property p_implicit_free;
        @(posedge clk) disable iff (rst)
        mem_done && mem_done_implicit && !issue_now |=> total == $past(total);
    endproperty
    a_implicit_free: assert property (p_implicit_free) else $error("implicit access counted");

    property p_sdb_nonspec;
        @(posedge clk) disable iff (rst)
        $rose(spec_win_reg) |-> $past(!bar_spec && bar_valid);
    endproperty
    a_sdb_nonspec: assert property (p_sdb_nonspec) else $error("speculative-data barrier taken speculatively");

    property p_no_alloc;
        @(posedge clk) disable iff (rst)
        issue_now && cur_cmov_reg && spec_win_reg |=> mem_no_alloc_reg;
    endproperty
    a_no_alloc: assert property (p_no_alloc) else $error("dependent access may allocate");

    property p_ibr;
        @(posedge clk) disable iff (rst)
        ibr_valid && ibr_cmov_dep && spec_win_reg |=> ibr_no_alloc_reg;
    endproperty
    a_ibr: assert property (p_ibr) else $error("dependent branch may allocate");

    c_strong_issue: cover property (@(posedge clk) disable iff (rst) issue_now && cur_type_reg == MAO_STRONG);
    c_bar_done:     cover property (@(posedge clk) disable iff (rst) bar_done_reg && bar_kind_reg == MAO_BAR_DATA_SYNC);
    c_sdb_window:   cover property (@(posedge clk) disable iff (rst) issue_now && spec_win_reg && cur_cmov_reg);
    c_multi_word:   cover property (@(posedge clk) disable iff (rst) issue_now && !seq_first && seq_last);

endmodule

// >>> testbench/mao_mem_model.sv
// Memory system behind the port: fixed four-cycle completion, optional stall
module mao_mem_model
    import mao_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  stall,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic [MAO_ADDR_W-1:0] addr,
    input  wire logic                  implicit,
    input  wire logic                  no_alloc,
    input  wire mao_mem_e              typ,
    output logic                       done,
    output mao_mem_e                   done_type,
    output logic                       done_implicit
);
    logic [3:0]            dv_reg = 4'h0;
    logic [3:0]            di_reg = 4'h0;
    logic [7:0]            dt_reg = 8'h00;
    int                    inflight = 0;
    logic [MAO_ADDR_W-1:0] alog[$];
    int                    blog[$];
    logic                  nlog[$];
    wire logic             take = req_valid && req_ready;
    assign done = dv_reg[3];
    assign done_implicit = di_reg[3];
    // Class lines are stale outside a completion, so show the inverse
    assign done_type = mao_mem_e'(dv_reg[3] ? dt_reg[7:6] : ~dt_reg[7:6]);
    always @(posedge clk) begin
        req_ready <= !stall && !rst;
        dv_reg <= rst ? 4'h0 : {dv_reg[2:0], take};
        di_reg <= {di_reg[2:0], implicit};
        dt_reg <= {dt_reg[5:0], typ};
        inflight <= rst ? 0 : inflight + int'(take && !implicit) - int'(done && !done_implicit);
        if (take) begin
            alog.push_back(addr);
            blog.push_back(inflight);
            nlog.push_back(no_alloc);
        end
    end
endmodule

// >>> testbench/tb_top.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("[ERR] t=%0t mismatch", $time); end end
module tb_top;
    import mao_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, ins_valid = 0, ins_write = 0, ins_has_pc = 0, ins_squash = 0, ins_spec = 0;
    logic ins_addr_dep = 0, ins_data_dep = 0, ins_ctrl_dep = 0, ins_cmov_dep = 0, stall = 0;
    logic impl_valid = 0, impl_write = 0, bar_valid = 0, bar_spec = 0, ibr_valid = 0, ibr_cmov_dep = 0;
    logic [MAO_ADDR_W-1:0] ins_base = 32'h0, impl_addr = 32'h0, mem_addr;
    logic [MAO_WORDS_W-1:0] ins_words = 5'h01;
    mao_op_e ins_op = MAO_OP_SINGLE;
    mao_mem_e ins_mem_type = MAO_NORMAL, mem_type, mem_done_type;
    mao_bar_e bar_kind = MAO_BAR_DATA_SYNC;
    logic ins_ready, impl_taken, mem_req_valid, mem_req_ready, mem_write, mem_implicit, mem_no_alloc;
    logic mem_done, mem_done_implicit, bar_done, flush_prefetch, ibr_no_alloc;
    int mismatches = 0, comparisons = 0, cycles = 0;
    mao_order DUT (.*);
    mao_mem_model mem (.clk(clk), .rst(rst), .stall(stall), .req_valid(mem_req_valid), .req_ready(mem_req_ready),
        .addr(mem_addr), .implicit(mem_implicit), .no_alloc(mem_no_alloc), .typ(mem_type), .done(mem_done),
        .done_type(mem_done_type), .done_implicit(mem_done_implicit));
    always #2 clk = ~clk;
    task automatic complete_run;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic put(mao_op_e op, logic wr, logic [31:0] b, logic [4:0] n, mao_mem_e mt, logic [2:0] dep);
        @(posedge clk);
        ins_op <= op;
        ins_write <= wr;
        ins_base <= b;
        ins_words <= n;
        ins_mem_type <= mt;
        {ins_ctrl_dep, ins_data_dep, ins_addr_dep} <= dep;
        ins_valid <= 1'b1;
        do @(posedge clk); while (ins_ready !== 1'b1);
        ins_valid <= 1'b0;
    endtask
    task automatic drain;
        do @(posedge clk); while (!(ins_ready === 1'b1 && mem.inflight == 0 && mem_req_valid === 1'b0));
        repeat (2) @(posedge clk);
    endtask
    task automatic clr;
        mem.alog.delete();
        mem.blog.delete();
        mem.nlog.delete();
    endtask
    task automatic s_seq(mao_op_e op, logic [31:0] b, logic [4:0] n, logic [31:0] lo, int cnt);
        clr();
        put(op, 1'b0, b, n, MAO_NORMAL, 3'h0);
        drain();
        `CHK(mem.alog.size(), cnt)
        for (int i = 0; i < cnt; i++) `CHK(mem.alog[i], lo + 32'(4 * i))
    endtask
    // Second access must not be taken while the first is still in flight
    task automatic s_pair(mao_mem_e a, mao_mem_e b, logic wr, logic [2:0] dep);
        clr();
        put(MAO_OP_SINGLE, 1'b0, 32'h200, 5'h01, a, 3'h0);
        put(MAO_OP_SINGLE, wr, 32'h204, 5'h01, b, dep);
        drain();
        `CHK(mem.alog.size(), 2)
        `CHK(mem.blog[1], 0)
    endtask
    task automatic s_spec;
        clr();
        ins_spec <= 1'b1;
        put(MAO_OP_SINGLE, 1'b1, 32'h300, 5'h01, MAO_NORMAL, 3'h0);
        repeat (10) @(posedge clk);
        `CHK(mem.alog.size(), 0)
        ins_spec <= 1'b0;
        drain();
        `CHK(mem.alog.size(), 1)
    endtask
    task automatic s_impl;
        clr();
        impl_addr <= 32'h1000;
        impl_valid <= 1'b1;
        do @(posedge clk); while (impl_taken !== 1'b1);
        impl_valid <= 1'b0;
        drain();
        `CHK(mem.alog.size(), 1)
        `CHK(mem.alog[0], 32'h1000)
    endtask
    task automatic s_bar;
        for (int k = 1; k < 6; k++) begin
            clr();
            put(MAO_OP_SINGLE, 1'b0, 32'h400, 5'h01, MAO_DEV_SH, 3'h0);
            bar_kind <= mao_bar_e'(k);
            bar_valid <= 1'b1;
            do @(posedge clk); while (bar_done !== 1'b1);
            bar_valid <= 1'b0;
            `CHK(flush_prefetch, 1'b1)
            `CHK(mem.inflight, 0)
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic s_sdb;
        clr();
        bar_kind <= MAO_BAR_SPEC_DATA;
        bar_spec <= 1'b1;
        bar_valid <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            `CHK(bar_done, 1'b0)
        end
        // Stalled port keeps the window open for the dependent traffic
        stall <= 1'b1;
        put(MAO_OP_SINGLE, 1'b0, 32'h500, 5'h01, MAO_NORMAL, 3'h0);
        bar_spec <= 1'b0;
        repeat (3) @(posedge clk);
        bar_valid <= 1'b0;
        ibr_valid <= 1'b1;
        ibr_cmov_dep <= 1'b1;
        @(posedge clk);
        ibr_valid <= 1'b0;
        @(posedge clk);
        `CHK(ibr_no_alloc, 1'b1)
        ins_cmov_dep <= 1'b1;
        put(MAO_OP_SINGLE, 1'b0, 32'h504, 5'h01, MAO_NORMAL, 3'h0);
        ins_cmov_dep <= 1'b0;
        stall <= 1'b0;
        drain();
        `CHK(mem.nlog[1], 1'b1)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_seq(MAO_OP_SINGLE, 32'h80, 5'h01, 32'h80, 1);
        s_seq(MAO_OP_MULTI_INC, 32'h100, 5'h04, 32'h100, 4);
        s_seq(MAO_OP_MULTI_DEC, 32'h20C, 5'h03, 32'h200, 3);
        s_seq(MAO_OP_DUAL, 32'h40, 5'h02, 32'h40, 2);
        s_pair(MAO_DEV_NS, MAO_DEV_NS, 1'b0, 3'h0);
        s_pair(MAO_DEV_NS, MAO_STRONG, 1'b0, 3'h0);
        s_pair(MAO_DEV_SH, MAO_DEV_SH, 1'b1, 3'h0);
        s_pair(MAO_DEV_SH, MAO_STRONG, 1'b0, 3'h0);
        s_pair(MAO_STRONG, MAO_DEV_NS, 1'b0, 3'h0);
        s_pair(MAO_STRONG, MAO_DEV_SH, 1'b0, 3'h0);
        s_pair(MAO_NORMAL, MAO_NORMAL, 1'b0, 3'h1);
        s_pair(MAO_NORMAL, MAO_NORMAL, 1'b0, 3'h5);
        s_pair(MAO_NORMAL, MAO_NORMAL, 1'b1, 3'h2);
        s_spec();
        s_impl();
        s_bar();
        s_sdb();
        complete_run();
    end
endmodule
